//--- dv/rcr_supply_model.sv
// Partner model: slewing supply rail and calendar tick source
`timescale 1ns/10ps
module rcr_supply_model (
    input wire logic clk_i,
    input wire logic [7:0] target_i,
    input wire logic tick_en_i,
    output logic [7:0] level_o,
    output logic tick_o
);
    logic [2:0] div;

    // Start from a healthy rail with no ticks
    initial begin
        level_o = 8'ha0;
        div = 3'h0;
        tick_o = 1'b0;
    end

    // Rail moves one step a cycle, so every level between old and new is crossed
    // One tick every eight cycles while enabled; short seconds keep the run brief
    always @(posedge clk_i) begin
        if (level_o < target_i) begin
            level_o <= level_o + 8'h01;
        end else if (level_o > target_i) begin
            level_o <= level_o - 8'h01;
        end
        div <= tick_en_i ? div + 3'h1 : 3'h0;
        tick_o <= tick_en_i && (div == 3'h7);
    end
endmodule : rcr_supply_model

//--- dv/tb_top.sv
// Self-checking bench for the reset-cause and clock-retention block
`timescale 1ns/10ps
module tb_top;
    logic clk, rstn, hsel, hwrite, rdp, hready, hresp, sys_rst, irq, tick, tick_en;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, acc;
    logic [7:0] target, level, sec, min, hour, cb, cr;
    logic [3:0] req;
    logic [31:0] q[$];
    logic [7:0] cal[rcr_pkg::CAL_N];
    int mismatches, tests_run, nt;

    rcr_top dut (.ref_clk_i(clk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .supply_level_i(level), .ext_rst_req_i(req[0]), .wdt_rst_req_i(req[1]),
        .ill_rst_req_i(req[2]), .oth_rst_req_i(req[3]), .rtc_tick_i(tick),
        .sys_rst_o(sys_rst), .irq_o(irq), .sec_o(sec), .min_o(min), .hour_o(hour));
    rcr_supply_model env (.clk_i(clk), .target_i(target), .tick_en_i(tick_en),
        .level_o(level), .tick_o(tick));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Single AHB-Lite word transfer; waits on ready with no assumed latency
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        rdp <= !w;
        do @(posedge clk); while (hready !== 1'b1);
        rdp <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] o, input logic [31:0] d);
        xfer({24'h0, o}, 1'b1, d);
    endtask : wr

    // The expectation is queued first; the monitor takes it when the answer lands
    task automatic rd(input logic [7:0] o, input logic [31:0] e);
        q.push_back(e);
        xfer({24'h0, o}, 1'b0, 32'h0);
    endtask : rd

    task automatic wt(input logic v, input int n);
        while (sys_rst !== v && n > 0) begin
            @(posedge clk);
            n--;
        end
        chk(33'(sys_rst), 33'(v));
    endtask : wt

    task automatic rel();
        rstn <= 1'b1;
        cyc(3);
    endtask : rel

    task automatic calchk();
        for (int i = 0; i < rcr_pkg::CAL_N; i++) begin
            rd(rcr_pkg::OFS_CAL_BASE + 8'(4 * i), {24'h0, cal[i]});
        end
    endtask : calchk

    task automatic ctlchk(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        rd(rcr_pkg::OFS_CTRL_A, {24'h0, a});
        rd(rcr_pkg::OFS_CTRL_B, {24'h0, b});
        rd(rcr_pkg::OFS_CORR, {24'h0, c});
    endtask : ctlchk

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    // Read answers and the OKAY response are compared at the edge ready returns
    always @(posedge clk) begin
        if (rdp && hready === 1'b1) begin
            chk({hresp, hrdata}, {1'b0, q.pop_front()});
        end
    end

    // Counts the seconds the block really saw
    always @(posedge clk) begin
        if (tick === 1'b1) begin
            nt++;
        end
    end

    // Hang guard, far beyond the several hundred cycles the sequence needs
    initial begin
        #400000;
        mismatches++;
        conclude();
    end

    initial begin
        rstn = 1'b0;
        {hsel, hwrite, rdp, tick_en} = 4'h0;
        {htrans, haddr, hwdata} = '0;
        req = 4'h0;
        target = 8'ha0;
        {mismatches, tests_run, nt} = '0;
        void'($urandom(28));
        cyc(2);
        rel();
        // Power-on values and refused addresses
        rd(rcr_pkg::OFS_CAUSE, 32'h0);
        rd(rcr_pkg::OFS_DROOP_CFG, 32'h180);
        ctlchk(8'h00, 8'h00, 8'h00);
        wr(8'h48, 32'hffff_ffff);
        rd(8'h48, 32'h0);
        q.push_back(32'h0);
        xfer(32'h0000_0100, 1'b0, 32'h0);
        // Calendar at its wrap point, random control and storage values
        cal[0] = rcr_pkg::SEC_MAX;
        cal[1] = rcr_pkg::MIN_MAX;
        cal[2] = rcr_pkg::HOUR_MAX;
        for (int i = 3; i < rcr_pkg::CAL_N; i++) cal[i] = 8'($urandom);
        for (int i = 0; i < rcr_pkg::CAL_N; i++) wr(rcr_pkg::OFS_CAL_BASE + 8'(4 * i), 32'(cal[i]));
        cb = 8'($urandom);
        cr = 8'($urandom);
        wr(rcr_pkg::OFS_CTRL_A, 32'h1 << rcr_pkg::CTRL_A_RUN);
        wr(rcr_pkg::OFS_CTRL_B, {24'h0, cb});
        wr(rcr_pkg::OFS_CORR, {24'h0, cr});
        wr(rcr_pkg::OFS_IRQ_MASK, 32'h1);
        // Droop in reset mode, ticking throughout, release exactly at threshold
        nt = 0;
        target <= 8'h60;
        tick_en <= 1'b1;
        wt(1'b1, 100);
        cyc(40);
        target <= rcr_pkg::THR_RST;
        wt(1'b0, 100);
        tick_en <= 1'b0;
        cyc(3);
        rd(rcr_pkg::OFS_CAUSE, 32'h1);
        rd(rcr_pkg::OFS_CAUSE, 32'h0);
        cal[0] = 8'((nt - 1) % 60);
        cal[1] = 8'h00;
        cal[2] = 8'h00;
        chk(33'({sec, min, hour}), 33'({cal[0], cal[1], cal[2]}));
        calchk();
        ctlchk(8'h80, cb, cr);
        // Interrupt raised by both edges, masked, cleared one bit at a time
        rd(rcr_pkg::OFS_IRQ_STAT, 32'h3);
        chk(33'(irq), 33'h1);
        wr(rcr_pkg::OFS_IRQ_STAT, 32'h1);
        cyc(2);
        chk(33'(irq), 33'h0);
        rd(rcr_pkg::OFS_IRQ_STAT, 32'h2);
        wr(rcr_pkg::OFS_IRQ_STAT, 32'h2);
        rd(rcr_pkg::OFS_IRQ_STAT, 32'h0);
        // Every other reset source sets its own sticky bit and keeps the clock
        acc = 32'h0;
        for (int k = 0; k < 4; k++) begin
            req[k] <= 1'b1;
            cyc(1);
            req[k] <= 1'b0;
            wt(1'b1, 4);
            wt(1'b0, 8);
            acc = acc | (32'h2 << k);
            rd(rcr_pkg::OFS_CAUSE, acc);
        end
        calchk();
        ctlchk(8'h80, cb, cr);
        // Reset mode off: a droop only flags an event
        wr(rcr_pkg::OFS_DROOP_CFG, {24'h0, rcr_pkg::THR_RST});
        target <= 8'h60;
        cyc(60);
        chk(33'(sys_rst), 33'h0);
        rd(rcr_pkg::OFS_IRQ_STAT, 32'h1);
        target <= 8'ha0;
        cyc(60);
        wr(rcr_pkg::OFS_IRQ_STAT, 32'h3);
        // Power-on reset clears cause and control group but not calendar
        rstn <= 1'b0;
        cyc(2);
        rel();
        rd(rcr_pkg::OFS_CAUSE, 32'h0);
        ctlchk(8'h00, 8'h00, 8'h00);
        calchk();
        cyc(4);
        conclude();
    end
endmodule : tb_top

//--- shared/rcr_pkg.sv
// Package for the reset-cause and clock-retention block: map, fields, reset values, types
package rcr_pkg;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] OFS_CAUSE = 8'h00;
    localparam logic [7:0] OFS_DROOP_CFG = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_CTRL_A = 8'h10;
    localparam logic [7:0] OFS_CTRL_B = 8'h14;
    localparam logic [7:0] OFS_CORR = 8'h18;
    localparam logic [7:0] OFS_CAL_BASE = 8'h20;
    localparam logic [7:0] OFS_CAL_LAST = 8'h44;

    // Reset-cause register fields
    localparam int CAUSE_W = 5;
    localparam int CAUSE_DROOP = 0;
    localparam int CAUSE_EXT = 1;
    localparam int CAUSE_WDT = 2;
    localparam int CAUSE_ILL = 3;
    localparam int CAUSE_OTH = 4;

    // Droop configuration: threshold in bits 7:0, reset-mode enable in bit 8
    localparam int CFG_MODE_BIT = 8;
    localparam logic CFG_MODE_RST = 1'b1;
    localparam logic [7:0] THR_RST = 8'h80;

    // Interrupt status and mask fields
    localparam int IRQ_W = 2;
    localparam int IRQ_FALL = 0;
    localparam int IRQ_RISE = 1;

    // Clock control A: run enable for the calendar counters
    localparam int CTRL_A_RUN = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Calendar group slots, in address order
    localparam int CAL_N = 10;
    localparam int CAL_SEC = 0;
    localparam int CAL_MIN = 1;
    localparam int CAL_HOUR = 2;
    localparam logic [7:0] SEC_MAX = 8'h3b;
    localparam logic [7:0] MIN_MAX = 8'h3b;
    localparam logic [7:0] HOUR_MAX = 8'h17;

    typedef enum logic [0:0] {
        RCR_ST_ADDR = 1'b0,
        RCR_ST_DATA = 1'b1
    } rcr_bus_e;

    typedef logic [CAL_N-1:0][7:0] rcr_cal_t;

    // All power-on-reset state of the top module
    typedef struct packed {
        rcr_bus_e bus;
        logic [7:0] addr;
        logic hit;
        logic wr;
        logic ready;
        logic [31:0] rdata;
        logic [CAUSE_W-1:0] cause;
        logic mode;
        logic [7:0] thr;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic sys_rst;
        logic [7:0] ctl_a;
        logic [7:0] ctl_b;
        logic [7:0] corr;
    } rcr_regs_s;

    localparam rcr_regs_s REGS_RST = '{
        bus: RCR_ST_ADDR, addr: 8'h00, hit: 1'b0, wr: 1'b0, ready: 1'b1,
        rdata: 32'h0000_0000, cause: 5'h00, mode: CFG_MODE_RST, thr: THR_RST,
        irq_stat: 2'h0, irq_mask: 2'h0, irq: 1'b0, sys_rst: 1'b1,
        ctl_a: CTRL_RST, ctl_b: CTRL_RST, corr: CTRL_RST
    };

endpackage : rcr_pkg

//--- src/rcr_droop_det.sv
// Supply droop comparator with registered level and edge pulses
`timescale 1ns/10ps
module rcr_droop_det #(
    parameter int LVL_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic por_n_i,
    input wire logic [LVL_W-1:0] supply_i,
    input wire logic [LVL_W-1:0] threshold_i,
    output logic below_o,
    output logic fall_o,
    output logic rise_o
);

    typedef struct packed {
        logic below;
        logic fall;
        logic rise;
    } rcr_det_s;

    rcr_det_s det_ff;
    rcr_det_s nxt_det;

    // Below is strict: at the threshold the supply counts as good
    always_comb begin
        nxt_det.below = supply_i < threshold_i;
        nxt_det.fall = nxt_det.below && !det_ff.below;
        nxt_det.rise = !nxt_det.below && det_ff.below;
    end

    always_ff @(posedge ref_clk_i or negedge por_n_i) begin
        if (!por_n_i) begin
            det_ff <= '0;
        end else begin
            det_ff <= nxt_det;
        end
    end

    assign below_o = det_ff.below;
    assign fall_o = det_ff.fall;
    assign rise_o = det_ff.rise;

endmodule : rcr_droop_det

//--- src/rcr_top.sv
// Reset-cause recorder, droop reset generator and retained clock register file
`timescale 1ns/10ps
module rcr_top #(
    parameter int LVL_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic [LVL_W-1:0] supply_level_i,
    input wire logic ext_rst_req_i,
    input wire logic wdt_rst_req_i,
    input wire logic ill_rst_req_i,
    input wire logic oth_rst_req_i,
    input wire logic rtc_tick_i,
    output logic sys_rst_o,
    output logic irq_o,
    output logic [7:0] sec_o,
    output logic [7:0] min_o,
    output logic [7:0] hour_o
);

    // Power-on reset synchroniser; only the second stage is used
    logic [1:0] por_sync_ff;
    logic por_n;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            por_sync_ff <= 2'b00;
        end else begin
            por_sync_ff <= {por_sync_ff[0], 1'b1};
        end
    end

    assign por_n = por_sync_ff[1];

    localparam int CAUSE_W_L = rcr_pkg::CAUSE_W;

    // Register state and its next value; the detector below reads the threshold
    rcr_pkg::rcr_regs_s r_ff;
    rcr_pkg::rcr_regs_s nxt_r;
    rcr_pkg::rcr_cal_t cal_ff;
    rcr_pkg::rcr_cal_t nxt_cal;

    logic below;
    logic fall;
    logic rise;

    rcr_droop_det #(
        .LVL_W(LVL_W)
    ) u_det (
        .ref_clk_i(ref_clk_i),
        .por_n_i(por_n),
        .supply_i(supply_level_i),
        .threshold_i(r_ff.thr),
        .below_o(below),
        .fall_o(fall),
        .rise_o(rise)
    );

    // Calendar slot decode, shared by the read and write paths
    function automatic logic is_cal(input logic [7:0] a);
        return a >= rcr_pkg::OFS_CAL_BASE && a <= rcr_pkg::OFS_CAL_LAST;
    endfunction : is_cal

    function automatic logic [3:0] cal_idx(input logic [7:0] a);
        logic [5:0] d;
        d = a[7:2] - rcr_pkg::OFS_CAL_BASE[7:2];
        return d[3:0];
    endfunction : cal_idx

    // Next state: bus slave, calendar counting, cause capture, interrupts
    always_comb begin
        logic [CAUSE_W_L-1:0] ev;
        ev = '0;
        nxt_r = r_ff;
        nxt_cal = cal_ff;
        // Counting ignores sys_rst on purpose: the clock runs through any reset but power-on
        if (rtc_tick_i && r_ff.ctl_a[rcr_pkg::CTRL_A_RUN]) begin
            if (cal_ff[rcr_pkg::CAL_SEC] >= rcr_pkg::SEC_MAX) begin
                nxt_cal[rcr_pkg::CAL_SEC] = 8'h00;
                if (cal_ff[rcr_pkg::CAL_MIN] >= rcr_pkg::MIN_MAX) begin
                    nxt_cal[rcr_pkg::CAL_MIN] = 8'h00;
                    if (cal_ff[rcr_pkg::CAL_HOUR] >= rcr_pkg::HOUR_MAX) begin
                        nxt_cal[rcr_pkg::CAL_HOUR] = 8'h00;
                    end else begin
                        nxt_cal[rcr_pkg::CAL_HOUR] = cal_ff[rcr_pkg::CAL_HOUR] + 8'h01;
                    end
                end else begin
                    nxt_cal[rcr_pkg::CAL_MIN] = cal_ff[rcr_pkg::CAL_MIN] + 8'h01;
                end
            end else begin
                nxt_cal[rcr_pkg::CAL_SEC] = cal_ff[rcr_pkg::CAL_SEC] + 8'h01;
            end
        end
        // One wait state per transfer so that hrdata comes from a flip-flop
        case (r_ff.bus)
            rcr_pkg::RCR_ST_ADDR: begin
                if (hsel_i && htrans_i[1] && hready_i) begin
                    nxt_r.bus = rcr_pkg::RCR_ST_DATA;
                    nxt_r.addr = haddr_i[7:0];
                    nxt_r.hit = haddr_i[31:8] == 24'h000000;
                    nxt_r.wr = hwrite_i;
                    nxt_r.ready = 1'b0;
                end
            end
            rcr_pkg::RCR_ST_DATA: begin
                nxt_r.bus = rcr_pkg::RCR_ST_ADDR;
                nxt_r.ready = 1'b1;
                nxt_r.rdata = 32'h0000_0000;
                if (r_ff.hit && r_ff.wr) begin
                    if (is_cal(r_ff.addr)) begin
                        nxt_cal[cal_idx(r_ff.addr)] = hwdata_i[7:0];
                    end
                    case (r_ff.addr)
                        rcr_pkg::OFS_DROOP_CFG: begin
                            nxt_r.thr = hwdata_i[7:0];
                            nxt_r.mode = hwdata_i[rcr_pkg::CFG_MODE_BIT];
                        end
                        rcr_pkg::OFS_IRQ_STAT: nxt_r.irq_stat = r_ff.irq_stat & ~hwdata_i[1:0];
                        rcr_pkg::OFS_IRQ_MASK: nxt_r.irq_mask = hwdata_i[1:0];
                        rcr_pkg::OFS_CTRL_A: nxt_r.ctl_a = hwdata_i[7:0];
                        rcr_pkg::OFS_CTRL_B: nxt_r.ctl_b = hwdata_i[7:0];
                        rcr_pkg::OFS_CORR: nxt_r.corr = hwdata_i[7:0];
                        default: ;
                    endcase
                end else if (r_ff.hit) begin
                    if (is_cal(r_ff.addr)) begin
                        nxt_r.rdata = {24'h000000, cal_ff[cal_idx(r_ff.addr)]};
                    end
                    case (r_ff.addr)
                        rcr_pkg::OFS_CAUSE: begin
                            nxt_r.rdata = {27'h0000000, r_ff.cause};
                            nxt_r.cause[rcr_pkg::CAUSE_DROOP] = 1'b0;
                        end
                        rcr_pkg::OFS_DROOP_CFG: nxt_r.rdata = {23'h000000, r_ff.mode, r_ff.thr};
                        rcr_pkg::OFS_IRQ_STAT: nxt_r.rdata = {30'h00000000, r_ff.irq_stat};
                        rcr_pkg::OFS_IRQ_MASK: nxt_r.rdata = {30'h00000000, r_ff.irq_mask};
                        rcr_pkg::OFS_CTRL_A: nxt_r.rdata = {24'h000000, r_ff.ctl_a};
                        rcr_pkg::OFS_CTRL_B: nxt_r.rdata = {24'h000000, r_ff.ctl_b};
                        rcr_pkg::OFS_CORR: nxt_r.rdata = {24'h000000, r_ff.corr};
                        default: ;
                    endcase
                end
            end
            default: begin
                nxt_r.bus = rcr_pkg::RCR_ST_ADDR;
                nxt_r.ready = 1'b1;
            end
        endcase
        // Cause events are applied after the read clear, so a new event wins
        ev[rcr_pkg::CAUSE_DROOP] = below && r_ff.mode;
        ev[rcr_pkg::CAUSE_EXT] = ext_rst_req_i;
        ev[rcr_pkg::CAUSE_WDT] = wdt_rst_req_i;
        ev[rcr_pkg::CAUSE_ILL] = ill_rst_req_i;
        ev[rcr_pkg::CAUSE_OTH] = oth_rst_req_i;
        nxt_r.cause = nxt_r.cause | ev;
        // Droop resets only in reset mode; otherwise it only raises status
        nxt_r.sys_rst = (below && r_ff.mode) || (|ev[CAUSE_W_L-1:1]);
        nxt_r.irq_stat = nxt_r.irq_stat | {rise, fall};
        nxt_r.irq = |(nxt_r.irq_stat & nxt_r.irq_mask);
    end

    // Power-on state; the calendar below deliberately has no reset
    always_ff @(posedge ref_clk_i or negedge por_n) begin
        if (!por_n) begin
            r_ff <= rcr_pkg::REGS_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Calendar survives every reset including power-on
    always_ff @(posedge ref_clk_i) begin
        cal_ff <= nxt_cal;
    end

    assign hreadyout_o = r_ff.ready;
    assign hresp_o = 1'b0;
    assign hrdata_o = r_ff.rdata;
    assign sys_rst_o = r_ff.sys_rst;
    assign irq_o = r_ff.irq;
    assign sec_o = cal_ff[rcr_pkg::CAL_SEC];
    assign min_o = cal_ff[rcr_pkg::CAL_MIN];
    assign hour_o = cal_ff[rcr_pkg::CAL_HOUR];

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!por_n);

    // Reset requests in cause-bit order, and a flag for none pending
    logic [3:0] req_vec;
    logic quiet;
    assign req_vec = {oth_rst_req_i, ill_rst_req_i, wdt_rst_req_i, ext_rst_req_i};
    assign quiet = !ext_rst_req_i && !wdt_rst_req_i && !ill_rst_req_i && !oth_rst_req_i;

    // Droop in reset mode reaches the reset output two edges after the supply sample
    a_droop_holds_rst: assert property (
        (supply_level_i < r_ff.thr) && r_ff.mode && $stable(r_ff.thr) && $stable(r_ff.mode)
        |-> ##2 sys_rst_o
    ) else $error("droop did not assert internal reset");

    a_droop_releases: assert property (
        !below && quiet |=> !sys_rst_o
    ) else $error("internal reset held with good supply");

    a_irq_mode_only: assert property (
        below && !r_ff.mode && quiet |=> !sys_rst_o
            && (!r_ff.cause[rcr_pkg::CAUSE_DROOP] || $past(r_ff.cause[rcr_pkg::CAUSE_DROOP]))
    ) else $error("droop reset outside reset mode");

    a_droop_flag_set: assert property (
        below && r_ff.mode |=> r_ff.cause[rcr_pkg::CAUSE_DROOP]
    ) else $error("droop flag not set");

    a_por_clears_cause: assert property (
        $rose(por_n) |-> r_ff.cause == '0
    ) else $error("cause register not cleared by power-on");

    a_por_ctrl_reset: assert property (
        $rose(por_n) |-> r_ff.ctl_a == rcr_pkg::CTRL_RST && r_ff.ctl_b == rcr_pkg::CTRL_RST
            && r_ff.corr == rcr_pkg::CTRL_RST
    ) else $error("control group not reset by power-on");

    a_count_in_reset: assert property (
        sys_rst_o && rtc_tick_i && r_ff.ctl_a[rcr_pkg::CTRL_A_RUN] && sec_o < rcr_pkg::SEC_MAX
            && r_ff.bus == rcr_pkg::RCR_ST_ADDR
        |=> sec_o == $past(sec_o) + 8'h01
    ) else $error("seconds stalled during reset");

    a_read_clears_flag: assert property (
        r_ff.bus == rcr_pkg::RCR_ST_DATA && r_ff.hit && !r_ff.wr
            && r_ff.addr == rcr_pkg::OFS_CAUSE && !(below && r_ff.mode)
        |=> !r_ff.cause[rcr_pkg::CAUSE_DROOP] ##0 hreadyout_o
    ) else $error("cause read did not clear droop flag");

    a_cal_write_keeps: assert property (
        r_ff.bus == rcr_pkg::RCR_ST_DATA && r_ff.hit && r_ff.wr
            && r_ff.addr == rcr_pkg::OFS_CAL_LAST
        |=> cal_ff[rcr_pkg::CAL_N-1] == $past(hwdata_i[7:0])
    ) else $error("alarm weekday write lost");

    // Good supply with no request keeps the device running
    a_good_supply_run: assert property (
        (supply_level_i >= r_ff.thr) ##1 quiet |=> !sys_rst_o
    ) else $error("internal reset with good supply and no request");

    // A droop falling edge is always latched for the interrupt path
    a_fall_sets_stat: assert property (
        fall |=> r_ff.irq_stat[rcr_pkg::IRQ_FALL]
    ) else $error("droop event not latched in status");

    // Outside power-on reset, only a cause read may clear the droop flag
    a_flag_sticky: assert property (
        r_ff.cause[rcr_pkg::CAUSE_DROOP] && !(r_ff.bus == rcr_pkg::RCR_ST_DATA && r_ff.hit
            && !r_ff.wr && r_ff.addr == rcr_pkg::OFS_CAUSE)
        |=> r_ff.cause[rcr_pkg::CAUSE_DROOP]
    ) else $error("droop flag lost without a read");

    // Seconds wrap at their limit even while the device is held in reset
    a_sec_wrap: assert property (
        rtc_tick_i && r_ff.ctl_a[rcr_pkg::CTRL_A_RUN] && sec_o == rcr_pkg::SEC_MAX
            && r_ff.bus == rcr_pkg::RCR_ST_ADDR
        |=> sec_o == 8'h00
    ) else $error("seconds did not wrap");

    // Every other source resets the device and records itself
    a_req_sets_cause: assert property (
        !quiet |=> sys_rst_o
            && ((r_ff.cause[rcr_pkg::CAUSE_OTH:rcr_pkg::CAUSE_EXT] & $past(req_vec))
                == $past(req_vec))
    ) else $error("reset request not recorded");

    // Control group survives the other reset sources
    a_ctrl_kept_req: assert property (
        !quiet && r_ff.bus == rcr_pkg::RCR_ST_ADDR
        |=> r_ff.ctl_a == $past(r_ff.ctl_a) && r_ff.ctl_b == $past(r_ff.ctl_b)
            && r_ff.corr == $past(r_ff.corr)
    ) else $error("control group changed by a reset request");

    // Firmware sees the flag on the read that clears it
    a_cause_read_value: assert property (
        r_ff.bus == rcr_pkg::RCR_ST_DATA && r_ff.hit && !r_ff.wr
            && r_ff.addr == rcr_pkg::OFS_CAUSE
        |=> hrdata_o == {27'h0, $past(r_ff.cause)}
    ) else $error("cause read returned wrong value");

    c_droop_reset: cover property (below && r_ff.mode ##1 sys_rst_o ##[1:50] !sys_rst_o);
    c_cause_read: cover property (r_ff.bus == rcr_pkg::RCR_ST_DATA && !r_ff.wr
        && r_ff.addr == rcr_pkg::OFS_CAUSE && r_ff.cause[0]);
    c_irq_raised: cover property (!irq_o ##1 irq_o);
    c_other_reset: cover property (!quiet ##1 sys_rst_o);
    c_sec_wrap: cover property (rtc_tick_i && sec_o == rcr_pkg::SEC_MAX ##1 sec_o == 8'h00);

endmodule : rcr_top
